// ### core/scc_regs.vh
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
// register offsets (word index on the plain port)
`define SCC_ADDR_MODE      3'h0
`define SCC_ADDR_CTL       3'h1
`define SCC_ADDR_TXD       3'h2
`define SCC_ADDR_RXD       3'h3
`define SCC_ADDR_FLAGS     3'h4
`define SCC_ADDR_ENABLES   3'h5
// mode field positions
`define SCC_MODE_ROLE      0
`define SCC_MODE_CLOCK_POLARITY_SELECT      1
`define SCC_MODE_CLOCK_PHASE_SELECT      2
`define SCC_MODE_LSB       3
`define SCC_MODE_NODIV     4
`define SCC_MODE_PULL      5
`define SCC_MODE_LEN_LO    8
`define SCC_MODE_LEN_HI    11
// control field positions
`define SCC_CTL_EN         0
`define SCC_CTL_SRST       1
// flag positions
`define SCC_FLG_TBE        0
`define SCC_FLG_RBF        1
`define SCC_FLG_TEND       2
`define SCC_FLG_OE         3
`define SCC_FLG_BSY        7
// reset values
`define SCC_LEN_RESET      4'h7
`define SCC_TIMER_DIV_RST  8'h04
`endif

// ### core/scc_channel.v
// What this block does
// - undivided select 0: serial clock is timer output divided by two
// - undivided select 1: serial clock equals timer output; ignored in slave
// - bit order select 1 shifts lsb first, 0 msb first
// - mode bits 2 and 1 choose clock phase and polarity
// - role select 1 means master, 0 means slave
// - soft reset clears shifter and counter, reads 1 until done
// - module enable starts operation and master clock; clear stops both
// - master transfer starts on transmit write; write accepted at any time, even when not empty
// - transmit bits above frame length never reach serial output
// - receive buffer readable when full; bits above length read zero
// - receive buffer cleared on writing 1 to enable or soft reset
// - activity flag bit 7: master busy or slave select low while enabled
// - overrun and done flags clear only on write of one
// - receive-full flag read-only, cleared by reading receive buffer
// - transmit-empty resets to one, clears on transmit buffer write
// - enable bits 3..0 gate overrun, done, full, empty interrupts
// - interrupt request only when flag set and enabled
// - frame length codes 1..15 give 2..16 bits, reset 7
// - frame received while full overwrites buffer and sets overrun
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"

module scc_channel #(
  parameter [7:0] TIMER_DIV = `SCC_TIMER_DIV_RST
) (
  input  wire        i_core_clk,
  input  wire        i_rst_b,
  input  wire [2:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  output reg         o_irq,
  output reg         o_pull_enable,
  input  wire        i_serial_clock_pin,
  output reg         o_serial_clock_pin,
  output reg         o_serial_clock_oe,
  input  wire        i_serial_in_pin,
  output reg         o_serial_out_pin,
  input  wire        i_slave_select_pin_n
);

  // ==========================================================
  // registers
  // ==========================================================
  reg  [15:0] mode_q;
  reg         enable_q;
  reg         srst_q;
  reg  [15:0] txbuf_q;
  reg  [15:0] rxbuf_q;
  reg         tbe_q, rbf_q, tend_q, oe_q;
  reg  [3:0]  irq_en_q;
  reg  [15:0] shift_q;
  reg  [4:0]  cnt_q;
  reg         busy_q;
  reg         have_data_q;
  reg  [7:0]  tdiv_q;
  reg         half_q;
  reg         sclk_q;
  reg  [2:0]  sck_sync_q, sdi_sync_q, ss_sync_q;

  wire        role_master = mode_q[`SCC_MODE_ROLE];
  wire        clock_polarity_select        = mode_q[`SCC_MODE_CLOCK_POLARITY_SELECT];
  wire        clock_phase_select        = mode_q[`SCC_MODE_CLOCK_PHASE_SELECT];
  wire        lsb_first   = mode_q[`SCC_MODE_LSB];
  wire        nodiv       = mode_q[`SCC_MODE_NODIV];
  wire [3:0]  len_code    = mode_q[`SCC_MODE_LEN_HI:`SCC_MODE_LEN_LO];
  wire [4:0]  nbits       = {1'b0, len_code} + 5'h01;
  wire        wr_mode  = i_wr && (i_addr == `SCC_ADDR_MODE);
  wire        wr_ctl   = i_wr && (i_addr == `SCC_ADDR_CTL);
  wire        wr_txd   = i_wr && (i_addr == `SCC_ADDR_TXD);
  wire        wr_flags = i_wr && (i_addr == `SCC_ADDR_FLAGS);
  wire        wr_ie    = i_wr && (i_addr == `SCC_ADDR_ENABLES);
  wire        rd_rxd   = i_rd && (i_addr == `SCC_ADDR_RXD);

  // ==========================================================
  // frame length mask
  // ==========================================================
  // length mask bits
  reg  [15:0] len_mask;
  integer     k;
  always @* begin
    len_mask = 16'h0000;
    for (k = 0; k < 16; k = k + 1) begin
      if (k[4:0] < nbits) begin
        len_mask[k] = 1'b1;
      end
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  // stage 0 is read only by stage 1; edges use stages 1 and 2
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      sck_sync_q <= 3'h0;
      sdi_sync_q <= 3'h0;
      ss_sync_q  <= 3'h7;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], i_serial_clock_pin};
      sdi_sync_q <= {sdi_sync_q[1:0], i_serial_in_pin};
      ss_sync_q  <= {ss_sync_q[1:0], i_slave_select_pin_n};
    end
  end
  wire s_sck  = sck_sync_q[1];
  wire s_sdi  = sdi_sync_q[1];
  wire s_ss_n = ss_sync_q[1];
  wire s_rise = sck_sync_q[1] & ~sck_sync_q[2];
  wire s_fall = ~sck_sync_q[1] & sck_sync_q[2];

  // ==========================================================
  // master clock generation
  // ==========================================================
  // timer stands in for the external 16-bit timer; a one-cycle tick.
  // clock runs only when enabled
  wire timer_tick = enable_q && role_master && (tdiv_q == 8'h00);
  always @(posedge i_core_clk) begin
    if (!i_rst_b || !enable_q) begin
      tdiv_q <= 8'h00;
      half_q <= 1'b0;
    end else begin
      tdiv_q <= (tdiv_q == 8'h00) ? TIMER_DIV : tdiv_q - 8'h01;
      if (timer_tick) begin
        half_q <= ~half_q;
      end
    end
  end
  // divide by two: one serial half-period per timer tick
  // undivided: a serial half-period per half timer period
  wire m_half_tick = nodiv ? (timer_tick || (enable_q && role_master &&
                     tdiv_q == (TIMER_DIV - {1'b0, TIMER_DIV[7:1]}))) : timer_tick;

  // ==========================================================
  // shift engine
  // ==========================================================
  // leading edge of a bit period when the clock leaves idle level
  // sample edge: leading if phase 0, trailing if phase 1
  wire m_lead  = busy_q && m_half_tick && (sclk_q == clock_polarity_select);
  wire m_trail = busy_q && m_half_tick && (sclk_q != clock_polarity_select);
  wire s_lead  = (clock_polarity_select ? s_fall : s_rise) && !s_ss_n && !role_master;
  wire s_trail = (clock_polarity_select ? s_rise : s_fall) && !s_ss_n && !role_master;
  wire lead    = role_master ? m_lead : s_lead;
  wire trail   = role_master ? m_trail : s_trail;
  wire smp     = enable_q && (clock_phase_select ? trail : lead);
  wire shf     = enable_q && (clock_phase_select ? lead : trail);
  wire [3:0] out_idx = lsb_first ? 4'h0 : (nbits[3:0] - 4'h1);
  wire       last_bit = (cnt_q == nbits - 5'h01);
  wire [15:0] rx_word = lsb_first ? ((shift_q >> 1) | ({15'h0000, s_sdi} << (nbits - 5'h01)))
                                  : (((shift_q << 1) | {15'h0000, s_sdi}) & len_mask);
  wire       frame_done = smp && last_bit;
  wire       load_now = tbe_q == 1'b0 && have_data_q && (cnt_q == 5'h00) &&
                        (role_master ? !busy_q : 1'b1);

  // soft reset clears shifter and counter
  always @(posedge i_core_clk) begin
    if (!i_rst_b || srst_q) begin
      shift_q     <= 16'h0000;
      cnt_q       <= 5'h00;
      busy_q      <= 1'b0;
      sclk_q      <= 1'b0;
      have_data_q <= 1'b0;
    end else begin
      if (!busy_q) begin
        sclk_q <= clock_polarity_select;
      end else if (m_half_tick) begin
        sclk_q <= ~sclk_q;
      end
      if (wr_txd) begin
        have_data_q <= 1'b1;
      end
      if (!enable_q || (!role_master && s_ss_n)) begin
        // slave deselect discards the partial frame
        cnt_q  <= 5'h00;
        busy_q <= 1'b0;
      end else if (load_now && !wr_txd) begin
        shift_q     <= txbuf_q & len_mask;
        have_data_q <= 1'b0;
        busy_q      <= role_master;
      end else begin
        if (smp) begin
          shift_q <= rx_word;
          cnt_q   <= last_bit ? 5'h00 : cnt_q + 5'h01;
          if (last_bit && m_trail) begin
            busy_q <= 1'b0;
          end
        end
        if (role_master && busy_q && cnt_q == 5'h00 && !smp && m_trail && clock_phase_select == 1'b0) begin
          busy_q <= busy_q;
        end
        if (role_master && busy_q && m_trail && clock_phase_select && cnt_q == 5'h00 && sclk_q != clock_polarity_select) begin
          busy_q <= busy_q;
        end
      end
      if (frame_done && role_master && !clock_phase_select) begin
        busy_q <= 1'b1;
      end
      if (role_master && busy_q && !clock_phase_select && m_trail && cnt_q == 5'h00 && !smp) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial outputs
  // ==========================================================
  // only the masked bit position is driven
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_serial_out_pin   <= 1'b0;
      o_serial_clock_pin <= 1'b0;
      o_serial_clock_oe  <= 1'b0;
      o_pull_enable      <= 1'b0;
    end else begin
      // first bit goes out with the load so it leads the first clock edge
      if (load_now && !wr_txd) begin
        o_serial_out_pin <= lsb_first ? txbuf_q[0] : txbuf_q[out_idx];
      end else begin
        o_serial_out_pin <= lsb_first ? shift_q[0] : shift_q[out_idx];
      end
      // pin follows the next clock level, so edges lead the data change
      o_serial_clock_pin <= !busy_q ? clock_polarity_select : (m_half_tick ? ~sclk_q : sclk_q);
      o_serial_clock_oe  <= role_master && enable_q;
      o_pull_enable      <= mode_q[`SCC_MODE_PULL];
    end
  end

  // ==========================================================
  // register file and flags
  // ==========================================================
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      mode_q   <= {4'h0, `SCC_LEN_RESET, 8'h00};
      enable_q <= 1'b0;
      srst_q   <= 1'b0;
      txbuf_q  <= 16'h0000;
      rxbuf_q  <= 16'h0000;
      tbe_q    <= 1'b1;
      rbf_q    <= 1'b0;
      tend_q   <= 1'b0;
      oe_q     <= 1'b0;
      irq_en_q <= 4'h0;
    end else begin
      // mode writes accepted only while disabled
      // length field reset 7, code 0 kept as written
      if (wr_mode && !enable_q) begin
        mode_q <= {4'h0, i_wdata[11:8], 2'b00, i_wdata[5:0]};
      end
      if (wr_ctl) begin
        enable_q <= i_wdata[`SCC_CTL_EN];
      end
      // self-clearing soft reset, one cycle long
      srst_q <= wr_ctl && i_wdata[`SCC_CTL_SRST];
      // empty clears on write, sets when word moves to shifter
      if (wr_txd) begin
        txbuf_q <= i_wdata;
        tbe_q   <= 1'b0;
      end else if (load_now || srst_q) begin
        tbe_q <= 1'b1;
      end
      // clear receive buffer on enable or soft reset write
      // full clears on read, set wins
      if (wr_ctl && (i_wdata[`SCC_CTL_EN] || i_wdata[`SCC_CTL_SRST])) begin
        rxbuf_q <= 16'h0000;
      end else if (frame_done) begin
        rxbuf_q <= rx_word & len_mask;
      end
      if (frame_done) begin
        rbf_q <= 1'b1;
        if (rbf_q && !rd_rxd) begin
          oe_q <= 1'b1;
        end
      end else if (rd_rxd) begin
        rbf_q <= 1'b0;
      end
      if (wr_flags && i_wdata[`SCC_FLG_OE] && !(frame_done && rbf_q)) begin
        oe_q <= 1'b0;
      end
      if (frame_done && tbe_q) begin
        tend_q <= 1'b1;
      end else if (wr_flags && i_wdata[`SCC_FLG_TEND]) begin
        tend_q <= 1'b0;
      end
      if (wr_ie) begin
        irq_en_q <= i_wdata[3:0];
      end
    end
  end

  // ==========================================================
  // read data and interrupt request
  // ==========================================================
  // activity flag
  wire activity = role_master ? busy_q : (enable_q && !s_ss_n);
  wire [3:0] flags = {oe_q, tend_q, rbf_q, tbe_q};
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 16'h0000;
      o_irq   <= 1'b0;
    end else begin
      o_irq <= |(flags & irq_en_q);
      if (i_rd) begin
        case (i_addr)
          `SCC_ADDR_MODE:    o_rdata <= mode_q;
          `SCC_ADDR_CTL:     o_rdata <= {14'h0000, srst_q, enable_q};
          `SCC_ADDR_TXD:     o_rdata <= txbuf_q;
          `SCC_ADDR_RXD:     o_rdata <= rxbuf_q;
          `SCC_ADDR_FLAGS:   o_rdata <= {8'h00, activity, 3'h0, flags};
          `SCC_ADDR_ENABLES: o_rdata <= {12'h000, irq_en_q};
          default:           o_rdata <= 16'h0000;
        endcase
      end else begin
        o_rdata <= 16'h0000;
      end
    end
  end

endmodule // scc_channel
`default_nettype wire

// ### sim/scc_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
// ====================================
// port checker for the serial channel
module scc_checker #(
  parameter [7:0] TIMER_DIV = 8'h05
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic [2:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        o_irq,
  input wire logic        o_serial_clock_pin,
  input wire logic        o_serial_clock_oe
);
  logic [15:0] mode_q;
  logic        en_q;
  logic [3:0]  ie_q;
  logic [16:0] mask;
  // shadows; mode writes are dropped while enabled
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      mode_q <= 16'h0700;
      en_q   <= 1'b0;
      ie_q   <= 4'h0;
    end else if (i_wr) begin
      if (i_addr == `SCC_ADDR_MODE && !en_q) mode_q <= i_wdata;
      if (i_addr == `SCC_ADDR_CTL) en_q <= i_wdata[`SCC_CTL_EN];
      if (i_addr == `SCC_ADDR_ENABLES) ie_q <= i_wdata[3:0];
    end
  end
  // frame bits are length code plus one
  assign mask = (17'h2 << mode_q[11:8]) - 17'h1;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_rd_rxd; i_rd && i_addr == `SCC_ADDR_RXD; endsequence
  sequence s_rd_flg; i_rd && i_addr == `SCC_ADDR_FLAGS; endsequence
  // stable spans below assume TIMER_DIV of 5: toggle every 6 cycles, or 3 undivided
  sequence s_tick; $changed(o_serial_clock_pin) && o_serial_clock_oe; endsequence
  a_rxd_upper_zero: assert property (s_rd_rxd |=> (o_rdata & ~mask[15:0]) == 16'h0)
    else $error("receive data wider than frame");
  a_full_read_clear: assert property (s_rd_rxd ##2 s_rd_flg |=> !o_rdata[1])
    else $error("full flag kept after data read");
  a_flag_w1c: assert property (i_wr && i_addr == `SCC_ADDR_FLAGS && i_wdata[3:2] == 2'b11
    ##2 s_rd_flg |=> o_rdata[3:2] == 2'b00)
    else $error("flags not cleared by one");
  a_rxd_cleared: assert property (i_wr && i_addr == `SCC_ADDR_CTL && i_wdata[1:0] != 2'b00
    ##2 s_rd_rxd |=> o_rdata == 16'h0)
    else $error("receive data not cleared");
  a_clk_oe_role: assert property (o_serial_clock_oe == $past(en_q && mode_q[0]))
    else $error("clock drive not master and enabled");
  a_div_half: assert property ((s_tick and !mode_q[4]) |=> $stable(o_serial_clock_pin)[*5])
    else $error("divided clock too fast");
  a_div_full: assert property ((s_tick and mode_q[4]) |=> $stable(o_serial_clock_pin)[*2])
    else $error("undivided clock too fast");
  a_irq_masked: assert property ((ie_q == 4'h0)[*2] |-> !o_irq)
    else $error("request with all enables off");
endmodule // scc_checker
`default_nettype wire

// ### sim/scc_slave_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================
// far-side serial slave
module scc_slave_model (
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  input  wire logic        i_clock_polarity_select,
  input  wire logic        i_clock_phase_select,
  input  wire logic        i_lsb,
  input  wire logic [3:0]  i_len,
  input  wire logic        i_load,
  input  wire logic [15:0] i_word,
  output var  logic        o_miso,
  output var  logic [15:0] o_rx
);
  logic [15:0] tx_q;
  int          k = 0;
  function automatic int pos(int n);
    return i_lsb ? n : i_len - n;
  endfunction
  // first bit stands before the first edge
  always @(posedge i_load) begin
    tx_q = i_word;
    o_rx = 16'h0;
    k = 0;
    o_miso = i_word[pos(0)];
  end
  always @(i_sclk) begin
    if (i_sclk ^ i_clock_polarity_select ^ i_clock_phase_select) begin
      if (k <= i_len) o_rx[pos(k)] = i_mosi;
      k = k + 1;
    end else begin
      // past the frame the line no longer holds its value
      o_miso = (k <= i_len) ? tx_q[pos(k)] : ~o_miso;
    end
  end
endmodule // scc_slave_model
`default_nettype wire

// ### sim/scc_channel_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================
// register-level bench
module scc_channel_bench;
  logic        core_clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, ssel_n = 1'b1;
  logic        clock_polarity_select = 1'b0, clock_phase_select = 1'b0, lsb = 1'b0, load = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [3:0]  len = 4'h7;
  logic [15:0] wdata = 16'h0, word = 16'h0, d, m, msk, tw, mw;
  wire  [15:0] rdata, rx;
  wire         irq, sclk_out, sclk_oe, mosi, miso, sclk;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  // released clock wire rests at idle level
  assign sclk = sclk_oe ? sclk_out : clock_polarity_select;
  always #25 core_clk = ~core_clk;
  scc_channel #(.TIMER_DIV(8'h05)) u_dut (.i_core_clk(core_clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata),
    .o_irq(irq), .o_pull_enable(), .i_serial_clock_pin(sclk), .o_serial_clock_pin(sclk_out),
    .o_serial_clock_oe(sclk_oe), .i_serial_in_pin(miso), .o_serial_out_pin(mosi),
    .i_slave_select_pin_n(ssel_n));
  scc_slave_model u_model (.i_sclk(sclk), .i_mosi(mosi), .i_clock_polarity_select(clock_polarity_select), .i_clock_phase_select(clock_phase_select),
    .i_lsb(lsb), .i_len(len), .i_load(load), .i_word(word), .o_miso(miso), .o_rx(rx));
  task automatic reg_write(input logic [2:0] a, input logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  // data stands only in the cycle after the read edge
  task automatic reg_read(input logic [2:0] a, output logic [15:0] v);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [15:0] exp);
    reg_read(a, d);
    chk(d, exp);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0, irq}, {15'h0, e});
  endtask
  // one frame: slave word ready first, then the transmit write
  task automatic xfer(input logic [15:0] t, input logic [15:0] s);
    word = s;
    load = 1'b1;
    #1 load = 1'b0;
    // only written after the previous frame left the buffer empty
    reg_write(3'h2, t);
    d = 16'h0;
    // wait for full with activity gone, so an unread earlier frame does not end the wait
    for (int p = 0; p < 400 && !(d[1] && !d[7]); p++) reg_read(3'h4, d);
    chk(d & 16'h0082, 16'h0002);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard far above the several hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    chk_rd(3'h0, 16'h0700);
    chk_rd(3'h4, 16'h0001);
    chk_rd(3'h5, 16'h0000);
    chk_rd(3'h6, 16'h0000);
    // every clock mode, both orders, boundary lengths
    for (int i = 0; i < 4; i++) begin
      reg_write(3'h1, 16'h0);
      clock_polarity_select = i[1];
      clock_phase_select = i[0];
      lsb = i[0];
      len = (i == 0) ? 4'h7 : (i == 1) ? 4'hf : (i == 2) ? 4'h1 : 4'h4;
      m = {4'h0, len, 3'h0, i[1], lsb, clock_phase_select, clock_polarity_select, 1'b1};
      msk = 16'((17'h2 << len) - 17'h1);
      tw = 16'hb4e1 + 16'(i);
      mw = 16'h6c39 - 16'(i);
      reg_write(3'h0, m);
      chk_rd(3'h0, m);
      reg_write(3'h1, 16'h0003);
      chk_rd(3'h3, 16'h0000);
      reg_write(3'h0, 16'h0f00);
      chk_rd(3'h0, m);
      xfer(tw, mw);
      chk(rx, tw & msk);
      chk_rd(3'h3, mw & msk);
      chk_rd(3'h4, 16'h0005);
      reg_write(3'h4, 16'h000c);
      chk_rd(3'h4, 16'h0001);
    end
    // second frame lands on an unread one
    xfer(16'h0011, 16'h0015);
    xfer(16'h0002, 16'h000a);
    chk_rd(3'h4, 16'h000f);
    reg_write(3'h5, 16'h0008);
    irq_is(1'b1);
    reg_write(3'h4, 16'h0004);
    chk_rd(3'h4, 16'h000b);
    irq_is(1'b1);
    reg_write(3'h4, 16'h0008);
    irq_is(1'b0);
    chk_rd(3'h3, 16'h000a);
    chk_rd(3'h4, 16'h0001);
    reg_write(3'h5, 16'h0001);
    irq_is(1'b1);
    reg_write(3'h5, 16'h0006);
    irq_is(1'b0);
    reg_write(3'h5, 16'h0000);
    // slave role: activity follows the select line
    reg_write(3'h1, 16'h0000);
    clock_polarity_select = 1'b0;
    reg_write(3'h0, 16'h0700);
    reg_write(3'h1, 16'h0001);
    @(posedge core_clk) ssel_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_rd(3'h4, 16'h0081);
    @(posedge core_clk) ssel_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk_rd(3'h4, 16'h0001);
    end_sim;
  end
endmodule // scc_channel_bench
bind scc_channel scc_checker #(.TIMER_DIV(TIMER_DIV)) u_chk (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_serial_clock_pin(o_serial_clock_pin),
  .o_serial_clock_oe(o_serial_clock_oe));
`default_nettype wire
